// >>> dpk_pkg.sv
/*
 * Constants shared by the debug port key access block: register indices,
 * field positions, reset values, key signatures and timing figures.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
`default_nettype none

package dpk_pkg;

    // Register indices in the control/status space.
    localparam logic [3:0] REG_IF_REV = 4'h0;
    localparam logic [3:0] REG_ERR_SIG = 4'h1;
    localparam logic [3:0] REG_PHY_CTRL_A = 4'h2;
    localparam logic [3:0] REG_PHY_CTRL_B = 4'h3;
    localparam logic [3:0] REG_KEY_FLAGS = 4'h7;
    localparam logic [3:0] REG_RST_REQ = 4'h8;
    localparam logic [3:0] REG_CLK_SEL = 4'h9;
    localparam logic [3:0] REG_SYS_CTRL = 4'ha;
    localparam logic [3:0] REG_SYS_STATE = 4'hb;
    localparam logic [3:0] REG_MEM_CHECK = 4'hc;

    // Field positions.
    localparam int REV_LSB = 4;
    localparam int PHY_CONTROL_SECONDARY_DISABLE = 2;
    localparam int KEY_ERASE_BIT = 3;
    localparam int KEY_PROG_BIT = 4;
    localparam int KEY_ROW_BIT = 5;
    localparam int SYS_KEEP_CLK_BIT = 0;
    localparam int SYS_COMMIT_BIT = 1;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_ROW_BIT = 2;
    localparam int ST_PROG_BIT = 3;
    localparam int ST_SLEEP_BIT = 4;
    localparam int ST_RST_BIT = 5;

    // Masks of writable bits and reset values.
    localparam logic [7:0] PHY_CONTROL_PRIMARY_MASK = 8'hbf;
    localparam logic [7:0] PHY_CONTROL_SECONDARY_MASK = 8'h1c;
    localparam logic [7:0] CLK_SEL_MASK = 8'h03;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] RST_RELEASE = 8'h00;
    localparam logic [7:0] SYS_CTRL_RESET = 8'h01;

    // Key signatures, shifted in least significant byte first.
    localparam logic [63:0] KEY_FULL_ERASE = 64'h4e564d4572617365;
    localparam logic [63:0] KEY_PROGRAM = 64'h4e564d50726f6720;
    localparam logic [63:0] KEY_CONFIG_ROW = 64'h4e564d5573267465;
    localparam logic [3:0] KEY_BYTES = 4'h8;

    // Information block sizes in bytes.
    localparam logic [4:0] INFO_FULL_BYTES = 5'h10;
    localparam logic [4:0] INFO_FAMILY_BYTES = 5'h08;

    // Row update window in RAM byte addresses.
    localparam int ROW_BYTES = 32;

    // Brown-out detector active field forced during erase.
    localparam logic [1:0] BOD_ACTIVE_ON = 2'h1;

    // Guard time base in port clock cycles, halved per step; last code is off.
    localparam logic [7:0] GUARD_BASE = 8'h80;
    localparam logic [2:0] GUARD_OFF = 3'h7;

endpackage

`default_nettype wire

// >>> dpk_key_access.sv
/*
 * Access layer of a one-wire debug port: key entry and matching, readout of
 * the system information block, reset request sequencing, lock gating of the
 * system bus, configuration row update window, sync edge event and sleep view.
 * Assumes the link layer in front decodes frames and hands over byte strobes
 * and control/status accesses on ref_clk; lock, sleep and memory controller
 * status arrive from the system domain and are synchronised here.
 */
// What this block does
// - Information block readable at any time
// - Sixteen bytes full block, eight family only
// - Fixed byte layout of information block
// - Full erase key recognised, LSB first
// - Programming and row keys recognised
// - Key order free; erase keeps programming key
// - Erase key unconditional, cleared by disable/reset
// - Programming needs unlock, ends when done
// - Row key needs lock, cleared by write
// - Locked: system bus blocked, status allowed
// - Brown-out detector forced on during erase
// - Row mode writes only first 32 bytes
// - Commit bit starts copy; flag clears after
// - Row mode refuses SRAM read-back
// - Event on every sync rising edge
// - Port keeps running during sleep
// - Sleeping flag set in idle or deeper
// - Keep-clock bit defaults one, emulates sleep
// - Reset code asserts reset until zero written
// - Info block replaces key bytes, 64-bit keys
// - No key reply; block after guard time
`timescale 1ns/100ps
`default_nettype none

module dpk_key_access #(
    parameter logic [3:0] IF_REVISION = 4'h1,
    parameter logic [7:0] RESET_CODE = 8'h59,
    parameter logic [55:0] FAMILY_IDENTIFIER = 56'h464d4c59303031,
    parameter logic [23:0] MEM_CTRL_VERSION = 24'h503a31,
    parameter logic [23:0] DEBUG_VERSION = 24'h443a30,
    parameter logic [7:0] DEBUG_OSC_FREQ = 8'h33
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cs_write,
    input wire logic cs_read,
    input wire logic [3:0] cs_addr,
    input wire logic [7:0] cs_wdata,
    output logic [7:0] cs_rdata,
    input wire logic key_instr,
    input wire logic key_info_select,
    input wire logic key_info_full,
    input wire logic key_byte_valid,
    input wire logic [7:0] key_byte,
    output logic info_valid,
    output logic [7:0] info_data,
    input wire logic info_ready,
    input wire logic [2:0] link_error,
    input wire logic link_error_set,
    input wire logic sync_rise,
    output logic sync_event,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [15:0] bus_addr,
    output logic bus_grant,
    input wire logic lock_in,
    input wire logic sleep_in,
    input wire logic erase_done_in,
    input wire logic row_copy_done_in,
    input wire logic [2:0] mem_check_in,
    output logic system_reset,
    output logic erase_start,
    output logic [1:0] brownout_detector_active,
    output logic brownout_force,
    output logic row_copy_start,
    output logic keep_clock_on,
    output logic port_disabled,
    output logic [7:0] phy_control_a,
    output logic [1:0] clock_select
);

    // Synchronisers for the system domain levels.
    logic [3:0] sys_meta_reg;
    logic [3:0] sys_sync_reg;
    wire logic lock_flag = sys_sync_reg[0];
    wire logic sleeping_flag = sys_sync_reg[1];
    wire logic erase_done = sys_sync_reg[2];
    wire logic copy_done = sys_sync_reg[3];
    logic [2:0] check_meta_reg;
    logic [2:0] check_sync_reg;

    // Register state.
    logic [2:0] err_sig_reg;
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic full_erase_key_flag_reg;
    logic programming_key_flag_reg;
    logic config_row_key_flag_reg;
    logic sys_reset_reg;
    logic [1:0] clk_sel_reg;
    logic keep_clock_reg;
    logic erase_busy_reg;
    logic prog_active_reg;
    logic config_row_prog_active_reg;
    logic copy_busy_reg;
    logic copy_start_reg;
    logic erase_start_reg;

    // Key shifter and information block stream.
    logic [63:0] key_shift_reg;
    logic [3:0] key_count_reg;
    logic info_busy_reg;
    logic [4:0] info_idx_reg;
    logic [4:0] info_len_reg;
    logic [7:0] guard_reg;
    logic [7:0] info_data_reg;
    logic sync_event_reg;
    logic [7:0] rdata_reg;

    // Register decode.
    wire logic wr_ctrl_a = cs_write && cs_addr == dpk_pkg::REG_PHY_CTRL_A;
    wire logic wr_ctrl_b = cs_write && cs_addr == dpk_pkg::REG_PHY_CTRL_B;
    wire logic wr_key = cs_write && cs_addr == dpk_pkg::REG_KEY_FLAGS;
    wire logic wr_rst = cs_write && cs_addr == dpk_pkg::REG_RST_REQ;
    wire logic wr_clk = cs_write && cs_addr == dpk_pkg::REG_CLK_SEL;
    wire logic wr_sys = cs_write && cs_addr == dpk_pkg::REG_SYS_CTRL;
    wire logic rd_err = cs_read && cs_addr == dpk_pkg::REG_ERR_SIG;
    wire logic disable_write = wr_ctrl_b && cs_wdata[dpk_pkg::PHY_CONTROL_SECONDARY_DISABLE];
    wire logic port_clear = !rstn || disable_write;

    // Reset request: the code asserts, zero releases, anything else keeps state.
    wire logic rst_assert = wr_rst && cs_wdata == RESET_CODE;
    wire logic rst_release = wr_rst && cs_wdata == dpk_pkg::RST_RELEASE;
    wire logic rst_fall = sys_reset_reg && rst_release;

    // Key completion and matching; an information request takes the bytes.
    wire logic key_take = key_byte_valid && !info_busy_reg;
    wire logic key_last = key_take && key_count_reg == dpk_pkg::KEY_BYTES - 4'h1;
    wire logic [63:0] key_word = {key_byte, key_shift_reg[63:8]};
    wire logic hit_erase = key_last && key_word == dpk_pkg::KEY_FULL_ERASE;
    wire logic hit_prog = key_last && key_word == dpk_pkg::KEY_PROGRAM;
    wire logic hit_row = key_last && key_word == dpk_pkg::KEY_CONFIG_ROW;

    // Information block layout, byte 0 in the low bits.
    wire logic [127:0] info_block = {DEBUG_OSC_FREQ, dpk_pkg::ZERO_BYTE, DEBUG_VERSION,
                                     MEM_CTRL_VERSION, dpk_pkg::ZERO_BYTE, FAMILY_IDENTIFIER};
    wire logic info_start = key_instr && key_info_select;
    wire logic [4:0] info_len_next = key_info_full ? dpk_pkg::INFO_FULL_BYTES
                                                   : dpk_pkg::INFO_FAMILY_BYTES;
    wire logic [2:0] guard_code = ctrl_a_reg[2:0];
    wire logic [7:0] guard_load = guard_code == dpk_pkg::GUARD_OFF ? dpk_pkg::ZERO_BYTE
                                                                  : dpk_pkg::GUARD_BASE >> guard_code;
    wire logic info_fire = info_valid && info_ready;
    wire logic info_end = info_fire && info_idx_reg == info_len_reg - 5'h01;

    // Operation modes entered when the system reset is released.
    wire logic prog_enter = rst_fall && programming_key_flag_reg && !lock_flag;
    wire logic row_enter = rst_fall && config_row_key_flag_reg && lock_flag;
    wire logic prog_done = prog_active_reg && rst_assert;
    wire logic commit_write = wr_sys && cs_wdata[dpk_pkg::SYS_COMMIT_BIT] && config_row_prog_active_reg;

    // System bus gating by lock, row window and sleep.
    wire logic bus_awake = !sleeping_flag || keep_clock_reg;
    wire logic row_window = bus_write && bus_addr < 16'(dpk_pkg::ROW_BYTES);
    wire logic row_grant = config_row_prog_active_reg && row_window;
    assign bus_grant = bus_req && bus_awake && !sys_reset_reg && (!lock_flag || row_grant);

    // Status word.
    wire logic [7:0] sys_state = (8'(sys_reset_reg) << dpk_pkg::ST_RST_BIT)
                               | (8'(sleeping_flag) << dpk_pkg::ST_SLEEP_BIT)
                               | (8'(prog_active_reg) << dpk_pkg::ST_PROG_BIT)
                               | (8'(config_row_prog_active_reg) << dpk_pkg::ST_ROW_BIT)
                               | (8'(lock_flag) << dpk_pkg::ST_LOCK_BIT);
    wire logic [7:0] key_flags = (8'(config_row_key_flag_reg) << dpk_pkg::KEY_ROW_BIT)
                               | (8'(programming_key_flag_reg) << dpk_pkg::KEY_PROG_BIT)
                               | (8'(full_erase_key_flag_reg) << dpk_pkg::KEY_ERASE_BIT);

    // Read data selection; unmapped and reserved offsets read zero.
    logic [7:0] rdata_next;
    always_comb
    begin
        unique case (cs_addr)
            dpk_pkg::REG_IF_REV: rdata_next = 8'(IF_REVISION) << dpk_pkg::REV_LSB;
            dpk_pkg::REG_ERR_SIG: rdata_next = {5'h00, err_sig_reg};
            dpk_pkg::REG_PHY_CTRL_A: rdata_next = ctrl_a_reg;
            dpk_pkg::REG_PHY_CTRL_B: rdata_next = ctrl_b_reg;
            dpk_pkg::REG_KEY_FLAGS: rdata_next = key_flags;
            dpk_pkg::REG_RST_REQ: rdata_next = sys_reset_reg ? RESET_CODE : dpk_pkg::ZERO_BYTE;
            dpk_pkg::REG_CLK_SEL: rdata_next = {6'h00, clk_sel_reg};
            dpk_pkg::REG_SYS_CTRL: rdata_next = {7'h00, keep_clock_reg};
            dpk_pkg::REG_SYS_STATE: rdata_next = sys_state;
            dpk_pkg::REG_MEM_CHECK: rdata_next = {5'h00, check_sync_reg};
            default: rdata_next = dpk_pkg::ZERO_BYTE;
        endcase
    end

    // Two-stage synchronisers; the first stage feeds only the second.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sys_meta_reg <= 4'h0;
            sys_sync_reg <= 4'h0;
            check_meta_reg <= 3'h0;
            check_sync_reg <= 3'h0;
        end
        else
        begin
            sys_meta_reg <= {row_copy_done_in, erase_done_in, sleep_in, lock_in};
            sys_sync_reg <= sys_meta_reg;
            check_meta_reg <= mem_check_in;
            check_sync_reg <= check_meta_reg;
        end
    end

    // Port configuration; a disable write clears it and the keys.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
        begin
            ctrl_a_reg <= dpk_pkg::ZERO_BYTE;
            ctrl_b_reg <= {5'h00, disable_write, 2'h0};
            clk_sel_reg <= 2'h0;
            keep_clock_reg <= dpk_pkg::SYS_CTRL_RESET[dpk_pkg::SYS_KEEP_CLK_BIT];
            rdata_reg <= dpk_pkg::ZERO_BYTE;
        end
        else
        begin
            rdata_reg <= cs_read ? rdata_next : rdata_reg;
            if (wr_ctrl_a)
                ctrl_a_reg <= cs_wdata & dpk_pkg::PHY_CONTROL_PRIMARY_MASK;
            if (wr_ctrl_b)
                ctrl_b_reg <= cs_wdata & dpk_pkg::PHY_CONTROL_SECONDARY_MASK;
            if (wr_clk)
                clk_sel_reg <= cs_wdata[1:0] & dpk_pkg::CLK_SEL_MASK[1:0];
            if (wr_sys)
                keep_clock_reg <= cs_wdata[dpk_pkg::SYS_KEEP_CLK_BIT];
        end
    end

    // Error signature: a new error wins over the clearing read.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
            err_sig_reg <= 3'h0;
        else if (link_error_set)
            err_sig_reg <= link_error;
        else if (rd_err)
            err_sig_reg <= 3'h0;
    end

    // Key shifter counts eight bytes, then starts over.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear || (key_instr && !key_info_select))
        begin
            key_shift_reg <= 64'h0;
            key_count_reg <= 4'h0;
        end
        else if (key_take)
        begin
            key_shift_reg <= key_word;
            key_count_reg <= key_last ? 4'h0 : key_count_reg + 4'h1;
        end
    end

    // Key flags; no key clears another and none sends a reply.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
        begin
            full_erase_key_flag_reg <= 1'b0;
            programming_key_flag_reg <= 1'b0;
            config_row_key_flag_reg <= 1'b0;
        end
        else
        begin
            if (hit_erase)
                full_erase_key_flag_reg <= 1'b1;
            if (hit_prog)
                programming_key_flag_reg <= 1'b1;
            else if (prog_done)
                programming_key_flag_reg <= 1'b0;
            if (hit_row)
                config_row_key_flag_reg <= 1'b1;
            else if (wr_key && cs_wdata[dpk_pkg::KEY_ROW_BIT])
                config_row_key_flag_reg <= 1'b0;
        end
    end

    // System reset request and the modes that hang on its release.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
        begin
            sys_reset_reg <= 1'b0;
            prog_active_reg <= 1'b0;
            erase_busy_reg <= 1'b0;
            erase_start_reg <= 1'b0;
        end
        else
        begin
            if (rst_assert)
                sys_reset_reg <= 1'b1;
            else if (rst_release)
                sys_reset_reg <= 1'b0;
            erase_start_reg <= rst_assert && full_erase_key_flag_reg && !erase_busy_reg;
            if (erase_start_reg)
                erase_busy_reg <= 1'b1;
            else if (erase_busy_reg && erase_done)
                erase_busy_reg <= 1'b0;
            if (prog_enter)
                prog_active_reg <= 1'b1;
            else if (prog_done)
                prog_active_reg <= 1'b0;
        end
    end

    // Row update: copy completion brings the flag back to zero; row entry wins over it.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
        begin
            config_row_prog_active_reg <= 1'b0;
            copy_busy_reg <= 1'b0;
            copy_start_reg <= 1'b0;
        end
        else
        begin
            copy_start_reg <= commit_write && !copy_busy_reg;
            if (copy_start_reg)
                copy_busy_reg <= 1'b1;
            else if (copy_busy_reg && copy_done)
                copy_busy_reg <= 1'b0;
            if (row_enter)
                config_row_prog_active_reg <= 1'b1;
            else if (copy_busy_reg && copy_done)
                config_row_prog_active_reg <= 1'b0;
        end
    end

    // Information block stream after the guard time.
    always_ff @(posedge ref_clk)
    begin
        if (port_clear)
        begin
            info_busy_reg <= 1'b0;
            info_idx_reg <= 5'h00;
            info_len_reg <= dpk_pkg::INFO_FAMILY_BYTES;
            guard_reg <= dpk_pkg::ZERO_BYTE;
            info_data_reg <= dpk_pkg::ZERO_BYTE;
        end
        else if (info_start)
        begin
            info_busy_reg <= 1'b1;
            info_idx_reg <= 5'h00;
            info_len_reg <= info_len_next;
            guard_reg <= guard_load;
            info_data_reg <= info_block[7:0];
        end
        else if (info_busy_reg)
        begin
            if (guard_reg != dpk_pkg::ZERO_BYTE)
                guard_reg <= guard_reg - 8'h01;
            if (info_end)
                info_busy_reg <= 1'b0;
            else if (info_fire)
            begin
                info_idx_reg <= info_idx_reg + 5'h01;
                info_data_reg <= info_block[8 * (info_idx_reg[3:0] + 4'h1) +: 8];
            end
        end
    end

    // Sync edge event, one cycle per edge, never masked.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            sync_event_reg <= 1'b0;
        else
            sync_event_reg <= sync_rise;
    end

    // Outputs.
    assign info_valid = info_busy_reg && guard_reg == dpk_pkg::ZERO_BYTE;
    assign info_data = info_data_reg;
    assign sync_event = sync_event_reg;
    assign cs_rdata = rdata_reg;
    assign system_reset = sys_reset_reg;
    assign erase_start = erase_start_reg;
    assign brownout_force = erase_busy_reg;
    assign brownout_detector_active = erase_busy_reg ? dpk_pkg::BOD_ACTIVE_ON : 2'h0;
    assign row_copy_start = copy_start_reg;
    assign keep_clock_on = keep_clock_reg;
    assign port_disabled = ctrl_b_reg[dpk_pkg::PHY_CONTROL_SECONDARY_DISABLE];
    assign phy_control_a = ctrl_a_reg;
    assign clock_select = clk_sel_reg;

    // Checks on the guarded behaviour.
    locked_bus_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        bus_grant && lock_flag |-> config_row_prog_active_reg && bus_write)
        else $error("bus granted on a locked part outside the row window");
    row_window_limit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        bus_grant && lock_flag |-> bus_addr < 16'h0020)
        else $error("row write granted outside the first 32 bytes");
    reset_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rst_assert && !disable_write |=> system_reset throughout (!$past(rst_release))[*1])
        else $error("reset code did not assert system reset");
    reset_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        system_reset && !cs_write ##1 !cs_write |-> system_reset)
        else $error("system reset dropped without a zero write");
    erase_key_kept_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        full_erase_key_flag_reg && !disable_write |=> full_erase_key_flag_reg)
        else $error("erase key flag lost without port clear");
    prog_kept_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        hit_erase && programming_key_flag_reg && !prog_done && !disable_write |=> programming_key_flag_reg)
        else $error("programming key cleared by erase key");
    bod_forced_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        erase_start |=> brownout_force && brownout_detector_active == 2'h1)
        else $error("brown-out detector not forced during erase");
    sync_event_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        sync_rise |=> sync_event)
        else $error("sync edge produced no event");
    info_guard_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        info_start && guard_code != dpk_pkg::GUARD_OFF |=> !info_valid [*2])
        else $error("information byte sent inside the guard time");
    info_first_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        info_start |=> info_data == FAMILY_IDENTIFIER[7:0])
        else $error("information block does not open with the family byte");
    sleep_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cs_read && cs_addr == dpk_pkg::REG_SYS_STATE |=> cs_rdata[dpk_pkg::ST_SLEEP_BIT] == $past(sleeping_flag))
        else $error("sleeping flag not shown");

endmodule

`default_nettype wire

// >>> dpk_sys_model.sv
/*
 * System-side partner for the key access bench: lock bits, erase and row copy.
 * Assumes ref_clk and the start pulses of the key access block.
 */
`timescale 1ns/100ps
`default_nettype none

module dpk_sys_model (
    input wire logic ref_clk,
    input wire logic erase_start,
    input wire logic row_copy_start,
    output logic lock_in,
    output logic erase_done_in,
    output logic row_copy_done_in
);
    // Erase and row copy finish a few cycles after their start pulses.
    initial
    begin
        lock_in = 1'b1;
        erase_done_in = 1'b0;
        row_copy_done_in = 1'b0;
        forever
        begin
            @(posedge ref_clk);
            if (erase_start === 1'b1)
            begin
                repeat (8) @(posedge ref_clk);
                lock_in <= 1'b0;
                erase_done_in <= 1'b1;
                repeat (4) @(posedge ref_clk);
                erase_done_in <= 1'b0;
            end
            if (row_copy_start === 1'b1)
            begin
                repeat (4) @(posedge ref_clk);
                row_copy_done_in <= 1'b1;
                repeat (4) @(posedge ref_clk);
                row_copy_done_in <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> debug_port_key_access_test.sv
/*
 * Self-checking bench of the key access block.
 * Assumes the system-side partner model and inputs driven on the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module debug_port_key_access_test;
    localparam logic [55:0] FAM = 56'h464d4c59303031;
    localparam logic [23:0] MEMV = 24'h503a31, DBGV = 24'h443a30;
    localparam logic [7:0] OSC = 8'h33, RCODE = 8'h59;
    localparam logic [127:0] INFO_EXP = {OSC, 8'h00, DBGV, MEMV, 8'h00, FAM};
    logic ref_clk = 0, rstn, cs_write, cs_read, key_instr, key_info_select, key_info_full, key_byte_valid;
    logic info_valid, info_ready, link_error_set, sync_rise, sync_event, bus_req, bus_write, bus_grant;
    logic lock_in, sleep_in, erase_done_in, row_copy_done_in, system_reset, erase_start, brownout_force;
    logic row_copy_start, keep_clock_on, port_disabled, rd_seen = 0;
    logic [3:0] cs_addr;
    logic [7:0] cs_wdata, cs_rdata, key_byte, info_data, phy_control_a;
    logic [2:0] link_error, mem_check_in;
    logic [1:0] brownout_detector_active, clock_select;
    logic [15:0] bus_addr;
    logic [31:0] r;
    logic [7:0] exp_q [$];
    int n_errors = 0, check_count = 0;

    dpk_key_access #(.IF_REVISION(4'h1), .RESET_CODE(RCODE), .FAMILY_IDENTIFIER(FAM), .MEM_CTRL_VERSION(MEMV),
        .DEBUG_VERSION(DBGV), .DEBUG_OSC_FREQ(OSC)) dut (.ref_clk, .rstn, .cs_write, .cs_read, .cs_addr,
        .cs_wdata, .cs_rdata, .key_instr, .key_info_select, .key_info_full, .key_byte_valid, .key_byte,
        .info_valid, .info_data, .info_ready, .link_error, .link_error_set, .sync_rise, .sync_event, .bus_req,
        .bus_write, .bus_addr, .bus_grant, .lock_in, .sleep_in, .erase_done_in, .row_copy_done_in, .mem_check_in,
        .system_reset, .erase_start, .brownout_detector_active, .brownout_force, .row_copy_start, .keep_clock_on,
        .port_disabled, .phy_control_a, .clock_select);
    dpk_sys_model partner (.ref_clk, .erase_start, .row_copy_start, .lock_in, .erase_done_in, .row_copy_done_in);

    // The clock toggles every half period of 2 ns.
    always #2 ref_clk = ~ref_clk;

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cs_write = 1; cs_addr = a; cs_wdata = d; idle(1); cs_write = 0; idle(1);
    endtask
    // A read notes its expected byte; the monitor below compares it when the data lands.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        cs_read = 1; cs_addr = a; exp_q.push_back(e); idle(1); cs_read = 0; idle(1);
    endtask
    task automatic send_key(input logic [63:0] k);
        key_instr = 1; idle(1); key_instr = 0;
        for (int i = 0; i < 8; i++)
        begin
            key_byte_valid = 1; key_byte = k[8*i +: 8]; idle(1);
        end
        key_byte_valid = 0; idle(1);
        chk("no_reply", {7'h0, info_valid}, 8'h00);
    endtask
    task automatic get_info(input logic full);
        int n;
        key_info_select = 1; key_info_full = full; key_instr = 1; idle(1); key_instr = 0; key_info_select = 0;
        for (int i = 0; i < (full ? 16 : 8); i++)
        begin
            n = 0;
            while (info_valid !== 1'b1 && n < 300)
            begin
                idle(1); n++;
            end
            chk("info_data", info_data, INFO_EXP[8*i +: 8]);
            idle(1);
        end
        chk("info_end", {7'h0, info_valid}, 8'h00);
    endtask

    // Read data is taken from the queue the cycle after the read strobe.
    always @(posedge ref_clk) rd_seen <= cs_read;
    always @(negedge ref_clk) if (rd_seen === 1'b1) chk("cs_rdata", cs_rdata, exp_q.pop_front());

    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #80000;
        n_errors++;
        give_verdict();
    end

    // Main sequence of scenarios.
    initial
    begin
        {cs_write, cs_read, key_instr, key_info_select, key_info_full, key_byte_valid, link_error_set} = 0;
        {sync_rise, bus_req, bus_write, sleep_in, rstn} = 0;
        {cs_addr, cs_wdata, key_byte, link_error, mem_check_in, bus_addr} = 0;
        info_ready = 1;
        r = $urandom(32'hb986);
        idle(8); rstn = 1; idle(1);
        rd(dpk_pkg::REG_IF_REV, 8'h10); rd(dpk_pkg::REG_KEY_FLAGS, 8'h00); rd(4'h5, 8'h00);
        rd(dpk_pkg::REG_SYS_CTRL, dpk_pkg::SYS_CTRL_RESET);
        r = $urandom; wr(dpk_pkg::REG_PHY_CTRL_A, r[7:0]); rd(dpk_pkg::REG_PHY_CTRL_A, r[7:0] & dpk_pkg::PHY_CONTROL_PRIMARY_MASK);
        wr(dpk_pkg::REG_CLK_SEL, r[15:8]); chk("phy", phy_control_a, r[7:0] & dpk_pkg::PHY_CONTROL_PRIMARY_MASK);
        chk("clk", {6'h0, clock_select}, {6'h0, r[9:8]});
        get_info(1'b1); get_info(1'b0);
        mem_check_in = r[10:8]; link_error = 3'h3; link_error_set = 1; idle(1); link_error_set = 0; idle(3);
        rd(dpk_pkg::REG_ERR_SIG, 8'h03); rd(dpk_pkg::REG_ERR_SIG, 8'h00); rd(dpk_pkg::REG_MEM_CHECK, {5'h0, r[10:8]});
        send_key(dpk_pkg::KEY_CONFIG_ROW); rd(dpk_pkg::REG_KEY_FLAGS, 8'h20);
        wr(dpk_pkg::REG_RST_REQ, RCODE); wr(dpk_pkg::REG_RST_REQ, dpk_pkg::RST_RELEASE); idle(3);
        rd(dpk_pkg::REG_SYS_STATE, 8'h05);
        bus_req = 1; bus_write = 1; bus_addr = 16'd31; idle(1); chk("grant_row", {7'h0, bus_grant}, 8'h01);
        bus_addr = 16'd32; idle(1); chk("grant_out", {7'h0, bus_grant}, 8'h00);
        bus_write = 0; bus_addr = 16'd0; idle(1); chk("grant_rd", {7'h0, bus_grant}, 8'h00);
        wr(dpk_pkg::REG_SYS_CTRL, 8'h03); idle(12); rd(dpk_pkg::REG_SYS_STATE, 8'h01);
        wr(dpk_pkg::REG_KEY_FLAGS, 8'h20); rd(dpk_pkg::REG_KEY_FLAGS, 8'h00);
        send_key(dpk_pkg::KEY_PROGRAM); send_key(dpk_pkg::KEY_FULL_ERASE);
        rd(dpk_pkg::REG_KEY_FLAGS, 8'h18);
        wr(dpk_pkg::REG_RST_REQ, RCODE); idle(1);
        chk("bod", {5'h0, brownout_force, brownout_detector_active}, {6'h1, dpk_pkg::BOD_ACTIVE_ON});
        chk("grant_rst", {6'h0, system_reset, bus_grant}, 8'h02);
        rd(dpk_pkg::REG_SYS_STATE, 8'h21);
        idle(20); wr(dpk_pkg::REG_RST_REQ, dpk_pkg::RST_RELEASE); idle(3);
        rd(dpk_pkg::REG_SYS_STATE, 8'h08);
        chk("grant_open", {7'h0, bus_grant}, 8'h01);
        sleep_in = 1; idle(3); rd(dpk_pkg::REG_SYS_STATE, 8'h18);
        chk("grant_keep", {7'h0, bus_grant}, 8'h01);
        wr(dpk_pkg::REG_SYS_CTRL, 8'h00); idle(1); chk("grant_sleep", {7'h0, bus_grant}, 8'h00);
        sync_rise = 1; idle(1); sync_rise = 0; chk("sync_ev", {7'h0, sync_event}, 8'h01);
        idle(1); chk("sync_end", {7'h0, sync_event}, 8'h00);
        wr(dpk_pkg::REG_PHY_CTRL_B, 8'h04); idle(1); chk("disabled", {7'h0, port_disabled}, 8'h01);
        rd(dpk_pkg::REG_KEY_FLAGS, 8'h00); idle(2);
        give_verdict();
    end
endmodule

`default_nettype wire
